// file: vbic_pkg.sv
package vbic_pkg;
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          SCL_PERIOD_NS  = 10000;
   // Quarter of a link bit time, rounded down to whole pclk cycles.
   localparam int          QTR_CYCLES     = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int          NUM_CH         = 3;
   localparam int          CFG_W          = 8;
   localparam logic [4:0]  DEV_ADDR_FIXED = 5'h0b;
   localparam logic        DIR_WRITE      = 1'h0;
   localparam logic        DIR_READ       = 1'h1;
   localparam logic [1:0]  SUB_CODE_FIRST = 2'h1;
   localparam logic [1:0]  SUB_CODE_LAST  = 2'h3;
   localparam logic [5:0]  SUB_UPPER_ZERO = 6'h00;
   localparam logic [3:0]  BYTE_BITS      = 4'h8;
   localparam logic [3:0]  LAST_DATA_BIT  = 4'h7;
   localparam int          CFG_BIAS_LSB   = 0;
   localparam int          CFG_BIAS_W     = 3;
   localparam int          CFG_MUX_BIT    = 5;
   localparam int          CFG_FILT_LSB   = 6;
   localparam int          CFG_FILT_W     = 2;
   localparam int          IN_SCL         = 3;
   localparam int          IN_SDA         = 2;
   localparam logic [3:0]  IN_RESET       = 4'hc;
   localparam logic [2:0]  STEP_ADDR_W    = 3'h0;
   localparam logic [2:0]  STEP_SUB       = 3'h1;
   localparam logic [2:0]  STEP_WDATA     = 3'h2;
   localparam logic [2:0]  STEP_ADDR_R    = 3'h3;
   localparam logic [2:0]  STEP_RDATA     = 3'h4;
   localparam logic [7:0]  REG_CMD        = 8'h00;
   localparam logic [7:0]  REG_STAT       = 8'h04;
   localparam logic [7:0]  REG_STRAP      = 8'h08;
   localparam int          CMD_DATA_LSB   = 0;
   localparam int          CMD_CH_LSB     = 8;
   localparam int          CMD_RD_BIT     = 12;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_NACK_BIT  = 1;
   localparam int          STAT_DATA_LSB  = 8;
   typedef logic [CFG_W-1:0] vbic_cfg_t;
endpackage

// file: vbic_if.sv
`timescale 1ns/100ps
interface vbic_if;
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;
   // Open-drain wires with pull-ups: any enabled low driver wins.
   assign scl = m_scl_oe_n | m_scl_o;
   assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
   modport ctl (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
   modport device (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface

// file: vbic_dev.sv
// Operation
// - Master opens with start, address, write bit.
// - Strap pins set two low address bits.
// - Subaddress: six zero bits, two-bit channel code.
// - Write: ack subaddress, take data, ack, stop.
// - Device acks accepted address and subaddress bytes.
// - Read phase one ends with stop, no data.
// - Read phase two: start, address, read bit.
// - Device returns one byte of selected channel.
// - Master answers read byte with nack, stop.
// - Each channel read needs full two-phase sequence.
// - Single data byte per transaction only.
// - Codes one to three select channels.
// - Fields: bias 2:0, mux 5, filter 7:6.
// - Channel contents undefined until first write.
`timescale 1ns/100ps
module vbic_dev #(
   parameter int NUM_CH_P = vbic_pkg::NUM_CH
) (
   input  wire logic                                      pclk,
   input  wire logic                                      presetn,
   vbic_if.device                                         bus,
   input  wire logic                                      addr_strap_high_pin,
   input  wire logic                                      addr_strap_low_pin,
   output vbic_pkg::vbic_cfg_t [NUM_CH_P-1:0]             chan_cfg,
   output logic [NUM_CH_P-1:0]                            chan_cfg_valid,
   output logic [NUM_CH_P-1:0][vbic_pkg::CFG_BIAS_W-1:0]  chan_bias_mode,
   output logic [NUM_CH_P-1:0]                            chan_input_b,
   output logic [NUM_CH_P-1:0][vbic_pkg::CFG_FILT_W-1:0]  chan_clamp_filt
);
   import vbic_pkg::*;

   if (NUM_CH_P != int'(SUB_CODE_LAST)) begin : g_chk
      $error("vbic_dev: channel count must match the subaddress codes");
   end

   typedef enum logic [9:0] {
      S_IDLE      = 10'h001,
      S_ADDR      = 10'h002,
      S_ADDR_ACK  = 10'h004,
      S_SUB       = 10'h008,
      S_SUB_ACK   = 10'h010,
      S_WDATA     = 10'h020,
      S_WDATA_ACK = 10'h040,
      S_RDATA     = 10'h080,
      S_RDATA_ACK = 10'h100,
      S_SKIP      = 10'h200
   } vbic_dev_st_t;

   logic [3:0]  raw;
   logic [3:0]  s1_q;
   logic [3:0]  s2_q;
   logic [3:0]  s3_q;
   logic [3:0]  filt_q;
   logic [3:0]  filt_d;
   logic [3:0]  last_q;

   assign raw = {bus.scl, bus.sda, addr_strap_high_pin, addr_strap_low_pin};

   // A pin level counts once the second and third stages agree.
   for (genvar i = 0; i < 4; i++) begin : g_filt
      assign filt_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : filt_q[i];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= IN_RESET;
         s2_q   <= IN_RESET;
         s3_q   <= IN_RESET;
         filt_q <= IN_RESET;
         last_q <= IN_RESET;
      end else begin
         s1_q   <= raw;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
         last_q <= filt_q;
      end
   end

   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic        sda_in;
   logic [1:0]  strap;

   assign sda_in     = filt_q[IN_SDA];
   assign strap      = filt_q[1:0];
   assign scl_rise   = filt_q[IN_SCL] & ~last_q[IN_SCL];
   assign scl_fall   = ~filt_q[IN_SCL] & last_q[IN_SCL];
   assign start_cond = filt_q[IN_SCL] & last_q[IN_SCL] & last_q[IN_SDA] & ~sda_in;
   assign stop_cond  = filt_q[IN_SCL] & last_q[IN_SCL] & ~last_q[IN_SDA] & sda_in;

   vbic_dev_st_t                 st_q;
   vbic_dev_st_t                 st_d;
   logic [3:0]                   cnt_q;
   logic [3:0]                   cnt_d;
   logic [7:0]                   sh_q;
   logic [7:0]                   sh_d;
   logic [1:0]                   sub_q;
   logic [1:0]                   sub_d;
   logic                         rd_q;
   logic                         rd_d;
   logic                         sda_q;
   logic                         sda_d;
   vbic_cfg_t [NUM_CH_P-1:0]     cfg_q;
   vbic_cfg_t [NUM_CH_P-1:0]     cfg_d;
   logic [NUM_CH_P-1:0]          vld_q;
   logic [NUM_CH_P-1:0]          vld_d;
   logic                         byte_done;
   logic [1:0]                   sel;
   logic [1:0]                   code;

   assign byte_done = scl_fall && (cnt_q == BYTE_BITS);
   assign sel       = sub_q - SUB_CODE_FIRST;
   assign code      = sh_q[1:0];

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      sub_d = sub_q;
      rd_d  = rd_q;
      sda_d = sda_q;
      cfg_d = cfg_q;
      vld_d = vld_q;
      if (stop_cond) begin
         st_d  = S_IDLE;
         sda_d = 1'h1;
      end else if (start_cond) begin
         st_d  = S_ADDR;
         cnt_d = '0;
         sda_d = 1'h1;
      end else begin
         case (st_q)
            S_ADDR, S_SUB, S_WDATA: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], sda_in};
                  cnt_d = cnt_q + 4'h1;
               end else if (byte_done) begin
                  cnt_d = '0;
                  st_d  = S_SKIP;
                  if (st_q == S_ADDR) begin
                     if (sh_q[7:1] == {DEV_ADDR_FIXED, strap}) begin
                        st_d  = S_ADDR_ACK;
                        rd_d  = (sh_q[0] == DIR_READ);
                        sda_d = 1'h0;
                     end
                  end else if (st_q == S_SUB) begin
                     if (sh_q[7:2] == SUB_UPPER_ZERO && code >= SUB_CODE_FIRST
                         && code <= SUB_CODE_LAST) begin
                        st_d  = S_SUB_ACK;
                        sub_d = code;
                        sda_d = 1'h0;
                     end
                  end else begin
                     st_d       = S_WDATA_ACK;
                     cfg_d[sel] = sh_q;
                     vld_d[sel] = 1'h1;
                     sda_d      = 1'h0;
                  end
               end
            end
            S_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_d = '0;
                  if (rd_q) begin
                     st_d  = S_RDATA;
                     sh_d  = cfg_q[sel];
                     sda_d = cfg_q[sel][7];
                  end else begin
                     st_d  = S_SUB;
                     sda_d = 1'h1;
                  end
               end
            end
            S_SUB_ACK: begin
               if (scl_fall) begin
                  st_d  = S_WDATA;
                  sda_d = 1'h1;
               end
            end
            S_WDATA_ACK: begin
               if (scl_fall) begin
                  st_d  = S_SKIP;
                  sda_d = 1'h1;
               end
            end
            S_RDATA: begin
               if (scl_fall) begin
                  if (cnt_q == LAST_DATA_BIT) begin
                     st_d  = S_RDATA_ACK;
                     sda_d = 1'h1;
                  end else begin
                     cnt_d = cnt_q + 4'h1;
                     sh_d  = {sh_q[6:0], 1'h0};
                     sda_d = sh_q[6];
                  end
               end
            end
            S_RDATA_ACK: begin
               if (scl_fall) begin
                  st_d = S_SKIP;
               end
            end
            default: begin
               st_d = st_q;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q  <= S_IDLE;
         cnt_q <= '0;
         sh_q  <= '0;
         sub_q <= SUB_CODE_FIRST;
         rd_q  <= 1'h0;
         sda_q <= 1'h1;
         cfg_q <= '0;
         vld_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         sub_q <= sub_d;
         rd_q  <= rd_d;
         sda_q <= sda_d;
         cfg_q <= cfg_d;
         vld_q <= vld_d;
      end
   end

   // Open drain: the line is pulled low only while the bit is zero.
   assign bus.s_sda_o    = sda_q;
   assign bus.s_sda_oe_n = sda_q;
   assign chan_cfg       = cfg_q;
   assign chan_cfg_valid = vld_q;

   for (genvar c = 0; c < NUM_CH_P; c++) begin : g_fields
      assign chan_bias_mode[c]  = cfg_q[c][CFG_BIAS_LSB +: CFG_BIAS_W];
      assign chan_input_b[c]    = cfg_q[c][CFG_MUX_BIT];
      assign chan_clamp_filt[c] = cfg_q[c][CFG_FILT_LSB +: CFG_FILT_W];
   end
endmodule

// file: vbic_ctl.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module vbic_ctl #(
   parameter int QTR_P = vbic_pkg::QTR_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   vbic_if.ctl              bus
);
   import vbic_pkg::*;

   if (QTR_P < 8 || QTR_P > 255) begin : g_chk
      $error("vbic_ctl: quarter bit time must be 8 to 255 cycles");
   end

   typedef enum logic [3:0] {
      M_IDLE  = 4'h1,
      M_START = 4'h2,
      M_BIT   = 4'h4,
      M_STOP  = 4'h8
   } vbic_ctl_st_t;

   vbic_ctl_st_t  st_q, st_d;
   logic [31:0]   prdata_q, prdata_d;
   logic          pready_q, pready_d, pslverr_q, pslverr_d;
   logic [7:0]    wdat_q, wdat_d, rdat_q, rdat_d, rsh_q, rsh_d, tx;
   logic [1:0]    ch_q, ch_d, strap_q, strap_d, ph_q, ph_d;
   logic          rd_q, rd_d, go, nack_q, nack_d, scl_q, scl_d, sda_q, sda_d;
   logic [2:0]    step_q, step_d, sy_q;
   logic [3:0]    bit_q, bit_d;
   logic [7:0]    div_q, div_d;
   logic          acc, sda_in_q, sda_in_d, tick, rx;

   assign acc = psel & penable & pready_q;

   always_comb begin
      pready_d  = psel & ~penable;
      pslverr_d = 1'h0;
      prdata_d  = '0;
      wdat_d    = wdat_q;
      ch_d      = ch_q;
      rd_d      = rd_q;
      strap_d   = strap_q;
      go        = 1'h0;
      if (psel & ~penable) begin
         case (paddr)
            REG_CMD: prdata_d = '0;
            REG_STAT: begin
               prdata_d[STAT_BUSY_BIT]            = (st_q != M_IDLE);
               prdata_d[STAT_NACK_BIT]            = nack_q;
               prdata_d[STAT_DATA_LSB +: CFG_W]   = rdat_q;
            end
            REG_STRAP: prdata_d[1:0] = strap_q;
            default: pslverr_d = 1'h1;
         endcase
      end
      if (acc & pwrite) begin
         if (paddr == REG_STRAP) begin
            strap_d = pwdata[1:0];
         end else if (paddr == REG_CMD && st_q == M_IDLE) begin
            wdat_d = pwdata[CMD_DATA_LSB +: CFG_W];
            ch_d   = pwdata[CMD_CH_LSB +: 2];
            rd_d   = pwdata[CMD_RD_BIT];
            go     = 1'h1;
         end
      end
   end

   always_comb begin
      case (step_q)
         STEP_ADDR_W: tx = {DEV_ADDR_FIXED, strap_q, DIR_WRITE};
         STEP_SUB:    tx = {SUB_UPPER_ZERO, ch_q};
         STEP_ADDR_R: tx = {DEV_ADDR_FIXED, strap_q, DIR_READ};
         default:     tx = wdat_q;
      endcase
   end

   assign rx       = (step_q == STEP_RDATA);
   assign tick     = (div_q == 8'(QTR_P - 1));
   assign sda_in_d = (sy_q[1] == sy_q[2]) ? sy_q[1] : sda_in_q;

   always_comb begin
      st_d   = st_q;
      step_d = step_q;
      bit_d  = bit_q;
      ph_d   = ph_q;
      scl_d  = scl_q;
      sda_d  = sda_q;
      nack_d = nack_q;
      rdat_d = rdat_q;
      rsh_d  = rsh_q;
      div_d  = (st_q == M_IDLE || tick) ? 8'h00 : div_q + 8'h01;
      case (st_q)
         M_IDLE: begin
            if (go) begin
               st_d   = M_START;
               step_d = STEP_ADDR_W;
               ph_d   = 2'h0;
               nack_d = 1'h0;
            end
         end
         M_START: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               case (ph_q)
                  2'h0: begin
                     sda_d = 1'h1;
                     scl_d = 1'h1;
                  end
                  2'h1: sda_d = 1'h0;
                  2'h2: scl_d = 1'h0;
                  default: begin
                     st_d  = M_BIT;
                     bit_d = '0;
                  end
               endcase
            end
         end
         M_BIT: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               case (ph_q)
                  // Nack after the read byte is simply a released line.
                  2'h0: sda_d = (bit_q == BYTE_BITS || rx) ? 1'h1 : tx[3'(7 - bit_q)];
                  2'h1: scl_d = 1'h1;
                  2'h2: begin
                     if (bit_q != BYTE_BITS) begin
                        rsh_d = {rsh_q[6:0], sda_in_q};
                     end else if (!rx && sda_in_q) begin
                        nack_d = 1'h1;
                     end
                  end
                  default: begin
                     scl_d = 1'h0;
                     bit_d = bit_q + 4'h1;
                     if (bit_q == BYTE_BITS) begin
                        bit_d = '0;
                        st_d  = M_STOP;
                        if (!nack_q) begin
                           case (step_q)
                              STEP_ADDR_W: begin
                                 st_d   = M_BIT;
                                 step_d = STEP_SUB;
                              end
                              STEP_SUB: begin
                                 if (!rd_q) begin
                                    st_d   = M_BIT;
                                    step_d = STEP_WDATA;
                                 end
                              end
                              STEP_ADDR_R: begin
                                 st_d   = M_BIT;
                                 step_d = STEP_RDATA;
                              end
                              STEP_RDATA: rdat_d = rsh_q;
                              default: st_d = M_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
         end
         M_STOP: begin
            if (tick) begin
               ph_d = ph_q + 2'h1;
               case (ph_q)
                  2'h0: sda_d = 1'h0;
                  2'h1: scl_d = 1'h1;
                  2'h2: sda_d = 1'h1;
                  default: begin
                     st_d = M_IDLE;
                     if (rd_q && step_q == STEP_SUB && !nack_q) begin
                        st_d   = M_START;
                        step_d = STEP_ADDR_R;
                     end
                  end
               endcase
            end
         end
         default: st_d = M_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= '0;
         pready_q  <= 1'h0;
         pslverr_q <= 1'h0;
         wdat_q    <= '0;
         ch_q      <= SUB_CODE_FIRST;
         rd_q      <= 1'h0;
         strap_q   <= '0;
         st_q      <= M_IDLE;
         step_q    <= STEP_ADDR_W;
         bit_q     <= '0;
         ph_q      <= '0;
         scl_q     <= 1'h1;
         sda_q     <= 1'h1;
         nack_q    <= 1'h0;
         rdat_q    <= '0;
         rsh_q     <= '0;
         div_q     <= '0;
         sy_q      <= 3'h7;
         sda_in_q  <= 1'h1;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         wdat_q    <= wdat_d;
         ch_q      <= ch_d;
         rd_q      <= rd_d;
         strap_q   <= strap_d;
         st_q      <= st_d;
         step_q    <= step_d;
         bit_q     <= bit_d;
         ph_q      <= ph_d;
         scl_q     <= scl_d;
         sda_q     <= sda_d;
         nack_q    <= nack_d;
         rdat_q    <= rdat_d;
         rsh_q     <= rsh_d;
         div_q     <= div_d;
         sy_q      <= {sy_q[1:0], bus.sda};
         sda_in_q  <= sda_in_d;
      end
   end

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign bus.m_scl_o    = scl_q;
   assign bus.m_scl_oe_n = scl_q;
   assign bus.m_sda_o    = sda_q;
   assign bus.m_sda_oe_n = sda_q;
endmodule

// file: vbic_sva.sv
`timescale 1ns/100ps
module vbic_sva #(
   parameter int QTR_P = vbic_pkg::QTR_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic m_scl_o,
   input wire logic m_scl_oe_n,
   input wire logic m_sda_o,
   input wire logic m_sda_oe_n,
   input wire logic s_sda_o,
   input wire logic s_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   import vbic_pkg::*;
   logic       ps_scl_q, ps_sda_q, ok_q, ok_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] byte_q, byte_d;
   logic [7:0] sh_q, sh_d, addr_q, addr_d, hi_q, hi_d;
   wire        rise = scl & ~ps_scl_q;
   wire        ack  = rise & (bit_q == 4'h8);
   wire        strt = scl & ps_scl_q & ps_sda_q & ~sda;
   // Read data bits come from the device; the first one arrives before byte_q advances.
   wire        rd_bit = addr_q[0] & ((byte_q == 2'h1 && bit_q != 4'h9) ||
                                     (byte_q == 2'h0 && bit_q == 4'h9));
   always_comb begin
      bit_d = bit_q;
      byte_d = byte_q;
      sh_d = sh_q;
      addr_d = addr_q;
      ok_d = ok_q;
      hi_d = scl ? ((hi_q == 8'hff) ? hi_q : hi_q + 8'h1) : 8'h0;
      if (strt) begin
         bit_d = 4'h0;
         byte_d = 2'h0;
         ok_d = 1'h0;
      end else if (rise) begin
         bit_d = (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
         if (bit_q == 4'h9 && byte_q != 2'h3) byte_d = byte_q + 2'h1;
         if (bit_q != 4'h8) sh_d = {sh_q[6:0], sda};
         if (ack && byte_q == 2'h0) addr_d = sh_q;
         if (ack && byte_q == 2'h1) ok_d = ~sda;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {ps_scl_q, ps_sda_q, ok_q} <= 3'h7;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         {sh_q, addr_q, hi_q} <= 24'h0;
      end else begin
         {ps_scl_q, ps_sda_q, ok_q} <= {scl, sda, ok_d};
         bit_q <= bit_d;
         byte_q <= byte_d;
         {sh_q, addr_q, hi_q} <= {sh_d, addr_d, hi_d};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rst_release_a: assert property ($rose(presetn) |-> m_scl_oe_n && m_sda_oe_n && s_sda_oe_n)
      else $error("line driven right after reset");
   dev_edge_a: assert property ($changed(s_sda_oe_n) |-> !scl)
      else $error("device changed data while clock high");
   scl_high_a: assert property ($fell(scl) |-> hi_q >= 8'(QTR_P))
      else $error("clock high phase too short");
   addr_ack_a: assert property (ack && byte_q == 2'h0 && !sda |->
      sh_q[7:3] == DEV_ADDR_FIXED)
      else $error("foreign address acknowledged");
   sub_ack_a: assert property (ack && byte_q == 2'h1 && !addr_q[0] && !sda |->
      sh_q[7:2] == SUB_UPPER_ZERO && sh_q[1:0] != 2'h0)
      else $error("bad subaddress acknowledged");
   data_ack_a: assert property (ack && byte_q == 2'h2 && !addr_q[0] && ok_q |->
      !sda)
      else $error("data byte not acknowledged");
   rd_nack_a: assert property (ack && byte_q == 2'h1 && addr_q[0] |-> sda)
      else $error("read byte acknowledged");
   dev_quiet_a: assert property (rise && bit_q != 4'h8 && !rd_bit |-> s_sda_oe_n)
      else $error("device drove a master bit");
   cover property (ack && byte_q == 2'h2 && !addr_q[0] && !sda);
   cover property (ack && byte_q == 2'h1 && addr_q[0]);
   cover property (ack && byte_q == 2'h0 && sda);
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import vbic_pkg::*;
   localparam int                     QTR = 10;
   logic                              pclk = 1'h0;
   logic                              presetn = 1'h0;
   logic                              psel = 1'h0;
   logic                              penable = 1'h0;
   logic                              pwrite = 1'h0;
   logic [7:0]                        paddr = 8'h00;
   logic [31:0]                       pwdata = 32'h0;
   logic [31:0]                       prdata, r;
   logic                              pready, pslverr, e;
   logic                              strap_hi = 1'h1;
   logic                              strap_lo = 1'h0;
   vbic_cfg_t [NUM_CH-1:0]            chan_cfg;
   logic [NUM_CH-1:0]                 cfg_valid, in_b;
   logic [NUM_CH-1:0][CFG_BIAS_W-1:0] bias;
   logic [NUM_CH-1:0][CFG_FILT_W-1:0] filt;
   logic [7:0]                        vals [1:3] = '{8'hf5, 8'h3a, 8'h8c};
   logic                              ps_scl = 1'h1;
   logic                              ps_sda = 1'h1;
   logic [3:0]                        mcnt = 4'h8;
   logic [7:0]                        msh = 8'h0;
   logic [7:0]                        first_byte = 8'h0;
   int                                bad_count = 0;
   int                                total_checks = 0;
   always #12.5 pclk = ~pclk;
   vbic_if vif ();
   vbic_ctl #(.QTR_P(QTR)) vbic_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(vif));
   vbic_dev vbic_dev_i (.pclk(pclk), .presetn(presetn), .bus(vif),
      .addr_strap_high_pin(strap_hi), .addr_strap_low_pin(strap_lo), .chan_cfg(chan_cfg),
      .chan_cfg_valid(cfg_valid), .chan_bias_mode(bias), .chan_input_b(in_b),
      .chan_clamp_filt(filt));
   vbic_sva #(.QTR_P(QTR)) vbic_sva_i (.pclk(pclk), .presetn(presetn), .m_scl_o(vif.m_scl_o),
      .m_scl_oe_n(vif.m_scl_oe_n), .m_sda_o(vif.m_sda_o), .m_sda_oe_n(vif.m_sda_oe_n),
      .s_sda_o(vif.s_sda_o), .s_sda_oe_n(vif.s_sda_oe_n), .scl(vif.scl), .sda(vif.sda));
   // Captures the first byte after the most recent start on the wire.
   always @(posedge pclk) begin
      if (vif.scl && ps_scl && ps_sda && !vif.sda) mcnt <= 4'h0;
      else if (vif.scl && !ps_scl && mcnt < 4'h8) begin
         msh <= {msh[6:0], vif.sda};
         mcnt <= mcnt + 4'h1;
         if (mcnt == 4'h7) first_byte <= {msh[6:0], vif.sda};
      end
      ps_scl <= vif.scl;
      ps_sda <= vif.sda;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Waits for the slave as long as it takes; only the watchdog ends a hang.
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task xfer(input logic rd, input logic [1:0] ch, input logic [7:0] d);
      apb(1'h1, REG_CMD, 32'({rd, 2'h0, ch, d}));
      do begin
         apb(1'h0, REG_STAT, 32'h0);
      end while (r[STAT_BUSY_BIT] !== 1'h0);
   endtask
   task t_reset;
      chk(32'(chan_cfg), 32'h0);
      chk(32'(cfg_valid), 32'h0);
      chk({30'h0, vif.scl, vif.sda}, 32'h3);
   endtask
   task t_write;
      apb(1'h1, REG_STRAP, 32'h2);
      chk({31'h0, e}, 32'h0);
      for (int c = 1; c <= 3; c++) begin
         xfer(1'h0, 2'(c), vals[c]);
         chk(32'(r[STAT_NACK_BIT]), 32'h0);
         chk(32'(chan_cfg[c-1]), 32'(vals[c]));
         chk(32'(cfg_valid), 32'((1 << c) - 1));
         chk(32'({filt[c-1], in_b[c-1], bias[c-1]}), 32'({vals[c][7:5], vals[c][2:0]}));
         chk(32'(first_byte), 32'({DEV_ADDR_FIXED, strap_hi, strap_lo, DIR_WRITE}));
      end
   endtask
   task t_read;
      for (int c = 3; c >= 1; c--) begin
         xfer(1'h1, 2'(c), 8'h00);
         chk(32'(r[STAT_DATA_LSB +: 8]), 32'(vals[c]));
         chk(32'(r[STAT_NACK_BIT]), 32'h0);
         chk(32'(first_byte), 32'({DEV_ADDR_FIXED, strap_hi, strap_lo, DIR_READ}));
         chk({30'h0, vif.scl, vif.sda}, 32'h3);
      end
   endtask
   task t_refuse;
      apb(1'h1, REG_STRAP, 32'h1);
      xfer(1'h0, 2'h1, 8'h00);
      chk(32'(r[STAT_NACK_BIT]), 32'h1);
      strap_hi <= 1'h0;
      strap_lo <= 1'h1;
      xfer(1'h0, 2'h2, 8'h47);
      chk(32'(r[STAT_NACK_BIT]), 32'h0);
      xfer(1'h0, 2'h0, 8'h11);
      chk(32'(r[STAT_NACK_BIT]), 32'h1);
      chk(32'(chan_cfg), 32'({vals[3], 8'h47, vals[1]}));
      apb(1'h0, 8'h0c, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      apb(1'h0, REG_CMD, 32'h0);
      chk({31'h0, e}, 32'h0);
      chk(r, 32'h0);
      apb(1'h0, REG_STRAP, 32'h0);
      chk(32'(r[1:0]), 32'h1);
   endtask
   task summarize;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_write;
      t_read;
      t_refuse;
      summarize;
   end
   initial begin
      #(60000 * CLK_PERIOD_NS);
      bad_count++;
      summarize;
   end
endmodule
